/* pkg/smc_pkg.sv */
// shared constants and types for the sleep and clock gating controller
package smc_pkg;
   // ==========================================
   // sleep modes
   typedef enum logic [2:0] {
      SMC_MODE_IDLE = 3'h0,
      SMC_MODE_PDOWN = 3'h2,
      SMC_MODE_PSAVE = 3'h3,
      SMC_MODE_STDBY = 3'h6,
      SMC_MODE_ESTDBY = 3'h7
   } smc_mode_e;

   // ==========================================
   // clock source selection
   typedef enum logic [2:0] {
      SMC_SRC_RC2M = 3'h0,
      SMC_SRC_RC32M = 3'h1,
      SMC_SRC_RC32K = 3'h2,
      SMC_SRC_XOSC = 3'h3,
      SMC_SRC_PLL = 3'h4
   } smc_src_e;

   // ==========================================
   // controller states
   typedef enum logic [1:0] {
      SMC_ST_ACTIVE = 2'h0,
      SMC_ST_DRAIN = 2'h1,
      SMC_ST_SLEEP = 2'h2,
      SMC_ST_WAKE = 2'h3
   } smc_state_e;

   // ==========================================
   // widths and counts
   localparam int SMC_NPER = 8;
   localparam int SMC_CAL_W = 8;
   localparam int SMC_CLK_HZ = 100_000_000;
   localparam int SMC_WAKE_HALT_CYC = 4;
   localparam logic [2:0] SMC_WAKE_HALT_LAST = 3'(SMC_WAKE_HALT_CYC - 1);
   // low power oscillator: base rate and its 1 kHz tap
   localparam int SMC_LPO_HZ = 32_000;
   localparam int SMC_LPO_KHZ = 1_000;
   localparam int SMC_LPO_DIV = SMC_LPO_HZ / SMC_LPO_KHZ;
   // calibrated low oscillator: 32.768 kHz and 1.024 kHz
   localparam int SMC_RC32K_HZ = 32_768;
   localparam int SMC_RC32K_KHZ = 1_024;
   localparam int SMC_RC32K_DIV = SMC_RC32K_HZ / SMC_RC32K_KHZ;
   localparam logic [7:0] SMC_CAL_RESET = 8'h80;
   // pll multiplier range
   localparam logic [4:0] SMC_PLL_MIN = 5'h01;
   localparam logic [4:0] SMC_PLL_MAX = 5'h1f;
   // crystal modes, four ranges within 0.4 to 16 MHz
   localparam logic [1:0] SMC_XOSC_MODE_RESET = 2'h0;
   // calibrator step: last count of the 64-cycle step interval in clk cycles
   localparam logic [7:0] SMC_FLC_PERIOD = 8'h3f;
endpackage : smc_pkg

/* src/smc_sleep_ctrl.sv */
// sleep sequencing, clock source enables and peripheral clock gating
// ==========================================
// Overview of operation
// R1: system clock runs from 2MHz after reset
// R2: other sources and calibrators off at reset
// R3: low power oscillator runs while any user
// R4: low power oscillator gives 1kHz tick
// R5: calibrated low osc, two taps, writable trim
// R6: crystal has four selectable range modes
// R7: enabled calibrator continuously trims its oscillator
// R8: 32MHz oscillator retunable by calibration value
// R9: pll multiplier one through thirty-one
// R10: sleep entered only from active by instruction
// R11: wake via interrupt, resume after sleep
// R12: cpu halted four cycles after wake
// R13: state kept in sleep, reset restarts
// R14: enabled interrupts wake, filtered by mode
// R15: idle stops cpu and nvm after programming
// R16: power-down stops all, two-wire/port wake
// R17: power-save keeps rtc, rtc interrupts wake
// R18: standby keeps sources, rtc clock stopped
// R19: extended standby keeps sources and rtc
// R20: power reduction gates peripheral clock
// R21: mode select and enable qualify sleep
module smc_sleep_ctrl (
   input wire logic clk,
   input wire logic reset,
   // cpu side
   input wire logic sleepInstr,
   input wire logic sleepEnable,
   input wire logic [2:0] sleepModeSel,
   input wire logic nvmBusy,
   input wire logic irqAny,
   input wire logic irqTwiAddrMatch,
   input wire logic irqPortAsync,
   input wire logic irqRtc,
   input wire logic rtcEnable,
   output logic cpuHalt,
   output logic cpuClkEn,
   output logic nvmClkEn,
   output logic wakeStrobe,
   output logic sleeping,
   // clock source configuration
   input wire logic [2:0] sysClkSel,
   input wire logic rc32mEnable,
   input wire logic rc32kEnable,
   input wire logic xoscEnable,
   input wire logic [1:0] xoscMode,
   input wire logic pllEnable,
   input wire logic [4:0] pllFactor,
   input wire logic flc2mEnable,
   input wire logic flc32mEnable,
   input wire logic flcFast2m,
   input wire logic flcFast32m,
   input wire logic rc32kCalWrite,
   input wire logic [7:0] rc32kCalData,
   input wire logic rc32mCalWrite,
   input wire logic [7:0] rc32mCalData,
   input wire logic rtcUsesLowPowerOsc,
   input wire logic wdtEnable,
   // clock source status and controls
   output smc_pkg::smc_src_e sysClkSrc,
   output logic rc2mOn,
   output logic rc32mOn,
   output logic rc32kOn,
   output logic xoscOn,
   output logic [1:0] xoscModeOut,
   output logic pllOn,
   output logic [4:0] pllMult,
   output logic freq_lock_calibrator2mOn,
   output logic freq_lock_calibrator32mOn,
   output logic [7:0] rc2mCal,
   output logic [7:0] rc32mCal,
   output logic [7:0] rc32kCal,
   output logic low_power_oscOn,
   output logic lowPowerTick,
   output logic lowPowerKhzTick,
   output logic rc32kTick,
   output logic rc32kKhzTick,
   // peripheral domain gating
   input wire logic [7:0] powerReduce,
   output logic [7:0] perClkEn,
   output logic rtcClkEn,
   output logic evtClkEn
);
   import smc_pkg::*;

   // ==========================================
   // state
   smc_state_e state;
   smc_state_e next_state;
   smc_mode_e mode;
   logic [2:0] haltCnt;
   logic [7:0] flcCnt;

   // ==========================================
   // decode helpers
   function automatic logic modeValid(input logic [2:0] m);
      modeValid = (m == SMC_MODE_IDLE) || (m == SMC_MODE_PDOWN) || (m == SMC_MODE_PSAVE)
         || (m == SMC_MODE_STDBY) || (m == SMC_MODE_ESTDBY);
   endfunction

   function automatic logic [7:0] trimStep(input logic [7:0] cal, input logic fast);
      // saturating step keeps the trim inside its range
      if (fast) begin
         trimStep = (cal == 8'h00) ? cal : cal - 8'h01;
      end else begin
         trimStep = (cal == 8'hff) ? cal : cal + 8'h01;
      end
   endfunction

   // ==========================================
   // sleep entry and wake qualification
   // R10 R21 sleep entry gate
   wire sleepReq = sleepInstr && sleepEnable && modeValid(sleepModeSel);
   wire inIdle = (mode == SMC_MODE_IDLE);
   wire inPsave = (mode == SMC_MODE_PSAVE);
   wire inEstdby = (mode == SMC_MODE_ESTDBY);
   wire inStdby = (mode == SMC_MODE_STDBY);
   wire deepSleep = (state == SMC_ST_SLEEP) && !inIdle;
   wire rtcMode = inPsave || inEstdby;
   wire keepSources = inStdby || inEstdby;
   // R14 R16 R17 wake filtering
   wire asyncWake = irqTwiAddrMatch || irqPortAsync;
   wire rtcWake = rtcMode && rtcEnable && irqRtc;
   wire wakeReq = inIdle ? irqAny : (asyncWake || rtcWake);
   wire haltDone = (haltCnt == SMC_WAKE_HALT_LAST);

   always_comb begin
      next_state = state;
      case (state)
         SMC_ST_ACTIVE: begin
            if (sleepReq) begin
               next_state = SMC_ST_DRAIN;
            end
         end
         // R15 let programming finish
         SMC_ST_DRAIN: begin
            if (!nvmBusy) begin
               next_state = SMC_ST_SLEEP;
            end
         end
         SMC_ST_SLEEP: begin
            if (wakeReq) begin
               next_state = SMC_ST_WAKE;
            end
         end
         // R12 four halted cycles
         SMC_ST_WAKE: begin
            if (haltDone) begin
               next_state = SMC_ST_ACTIVE;
            end
         end
         default: next_state = SMC_ST_ACTIVE;
      endcase
   end

   // R13 reset restarts from active
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= SMC_ST_ACTIVE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mode <= SMC_MODE_IDLE;
      end else if (state == SMC_ST_ACTIVE && sleepReq) begin
         mode <= smc_mode_e'(sleepModeSel);
      end
   end

   always_ff @(posedge clk) begin
      if (reset || state != SMC_ST_WAKE) begin
         haltCnt <= '0;
      end else begin
         haltCnt <= haltCnt + 3'h1;
      end
   end

   // R11 wake pulse hands over to the interrupt controller
   always_ff @(posedge clk) begin
      if (reset) begin
         wakeStrobe <= 1'b0;
      end else begin
         wakeStrobe <= (state == SMC_ST_SLEEP) && wakeReq;
      end
   end

   // ==========================================
   // clock domain gating
   wire asleep = (state == SMC_ST_SLEEP);
   wire drainOrSleep = asleep || (state == SMC_ST_DRAIN);
   assign sleeping = asleep;
   // cpu halted from the sleep instruction until the halt count ends
   assign cpuHalt = (state != SMC_ST_ACTIVE);
   // R15 cpu and nvm stop, nvm kept during drain
   assign cpuClkEn = !drainOrSleep;
   assign nvmClkEn = !asleep;
   // R16 R18 peripherals stop in every sleep mode except idle
   wire perDomainOn = !deepSleep;
   assign evtClkEn = perDomainOn;
   // R17 R19 rtc runs in power-save and extended standby
   assign rtcClkEn = (!deepSleep || rtcMode) && rtcEnable;
   // R20 power reduction freezes peripherals
   assign perClkEn = perDomainOn ? ~powerReduce : 8'h00;

   // ==========================================
   // clock source enables
   logic rc32mReg;
   logic rc32kReg;
   logic xoscReg;
   logic pllReg;
   logic flc2mReg;
   logic flc32mReg;

   // R1 R2 all sources off except default after reset
   always_ff @(posedge clk) begin
      if (reset) begin
         rc32mReg <= 1'b0;
         rc32kReg <= 1'b0;
         xoscReg <= 1'b0;
         pllReg <= 1'b0;
         flc2mReg <= 1'b0;
         flc32mReg <= 1'b0;
         sysClkSrc <= SMC_SRC_RC2M;
      end else begin
         rc32mReg <= rc32mEnable;
         rc32kReg <= rc32kEnable;
         xoscReg <= xoscEnable;
         pllReg <= pllEnable;
         flc2mReg <= flc2mEnable;
         flc32mReg <= flc32mEnable;
         if (sysClkSel <= 3'(SMC_SRC_PLL)) begin
            sysClkSrc <= smc_src_e'(sysClkSel);
         end
      end
   end

   // R16 R18 sources stop in deep sleep unless standby variants
   wire srcRun = !deepSleep || keepSources;
   wire selRc2m = (sysClkSrc == SMC_SRC_RC2M);
   assign rc2mOn = srcRun && (selRc2m || flc2mReg);
   assign rc32mOn = srcRun && (rc32mReg || sysClkSrc == SMC_SRC_RC32M);
   assign rc32kOn = srcRun && (rc32kReg || sysClkSrc == SMC_SRC_RC32K);
   assign xoscOn = srcRun && (xoscReg || sysClkSrc == SMC_SRC_XOSC);
   assign pllOn = srcRun && (pllReg || sysClkSrc == SMC_SRC_PLL);
   // R7 calibrators run only while enabled and awake enough
   assign freq_lock_calibrator2mOn = flc2mReg && srcRun;
   assign freq_lock_calibrator32mOn = flc32mReg && srcRun;
   // R3 low power oscillator on while used
   assign low_power_oscOn = wdtEnable || (rtcUsesLowPowerOsc && rtcClkEn);

   // ==========================================
   // crystal mode and pll factor
   // R6 four crystal ranges
   always_ff @(posedge clk) begin
      if (reset) begin
         xoscModeOut <= SMC_XOSC_MODE_RESET;
      end else if (!xoscReg) begin
         xoscModeOut <= xoscMode;
      end
   end

   // R9 multiplier clamped to one through thirty-one
   wire [4:0] pllClamped = (pllFactor < SMC_PLL_MIN) ? SMC_PLL_MIN : pllFactor;
   always_ff @(posedge clk) begin
      if (reset) begin
         pllMult <= SMC_PLL_MIN;
      end else if (!pllReg && pllClamped <= SMC_PLL_MAX) begin
         pllMult <= pllClamped;
      end
   end

   // ==========================================
   // calibration values
   wire flcStep = (flcCnt == SMC_FLC_PERIOD);
   always_ff @(posedge clk) begin
      if (reset) begin
         flcCnt <= '0;
      end else begin
         flcCnt <= flcStep ? 8'h00 : flcCnt + 8'h01;
      end
   end

   // R5 software trim of the low oscillator
   always_ff @(posedge clk) begin
      if (reset) begin
         rc32kCal <= SMC_CAL_RESET;
      end else if (rc32kCalWrite) begin
         rc32kCal <= rc32kCalData;
      end
   end

   // R7 continuous trim of 2MHz oscillator
   always_ff @(posedge clk) begin
      if (reset) begin
         rc2mCal <= SMC_CAL_RESET;
      end else if (freq_lock_calibrator2mOn && flcStep) begin
         rc2mCal <= trimStep(rc2mCal, flcFast2m);
      end
   end

   // R8 retune by software, R7 trim when calibrator runs
   always_ff @(posedge clk) begin
      if (reset) begin
         rc32mCal <= SMC_CAL_RESET;
      end else if (rc32mCalWrite) begin
         rc32mCal <= rc32mCalData;
      end else if (freq_lock_calibrator32mOn && flcStep) begin
         rc32mCal <= trimStep(rc32mCal, flcFast32m);
      end
   end

   // ==========================================
   // oscillator tick generation
   // R4 low power oscillator with 1kHz tap
   smc_tick_div #(
      .BASE_DIV(SMC_CLK_HZ / SMC_LPO_HZ),
      .TAP_DIV(SMC_LPO_DIV)
   ) u_lpoDiv (
      .clk(clk),
      .reset(reset),
      .run(low_power_oscOn),
      .baseTick(lowPowerTick),
      .tapTick(lowPowerKhzTick)
   );

   // R5 calibrated low oscillator, two taps
   smc_tick_div #(
      .BASE_DIV(SMC_CLK_HZ / SMC_RC32K_HZ),
      .TAP_DIV(SMC_RC32K_DIV)
   ) u_rc32kDiv (
      .clk(clk),
      .reset(reset),
      .run(rc32kOn),
      .baseTick(rc32kTick),
      .tapTick(rc32kKhzTick)
   );
endmodule // smc_sleep_ctrl

/* src/smc_tick_div.sv */
// tick divider producing one-cycle enable pulses for an oscillator and its tap
module smc_tick_div #(
   parameter int BASE_DIV = 4,
   parameter int TAP_DIV = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   output logic baseTick,
   output logic tapTick
);
   import smc_pkg::*;

   logic [15:0] baseCnt;
   logic [15:0] tapCnt;
   wire baseWrap = (baseCnt == 16'(BASE_DIV - 1));
   wire tapWrap = (tapCnt == 16'(TAP_DIV - 1));

   always_ff @(posedge clk) begin
      if (reset || !run) begin
         baseCnt <= '0;
         tapCnt <= '0;
         baseTick <= 1'b0;
         tapTick <= 1'b0;
      end else begin
         baseCnt <= baseWrap ? '0 : baseCnt + 16'h0001;
         baseTick <= baseWrap;
         tapTick <= baseWrap && tapWrap;
         if (baseWrap) begin
            tapCnt <= tapWrap ? '0 : tapCnt + 16'h0001;
         end
      end
   end
endmodule // smc_tick_div

/* tb/sleep_mode_clock_gating_tb.sv */
// self-checking bench for the sleep and clock gating controller
module sleep_mode_clock_gating_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import smc_pkg::*;
   logic clk = 1'b0, reset = 1'b1, sleepEn = 1'b1, sleepReq = 1'b0, nvmStart = 1'b0;
   logic rtcEn = 1'b1, rc32mEn = 1'b0, rc32kEn = 1'b0, xoscEn = 1'b0, pllEn = 1'b0;
   logic flc2mEn = 1'b0, fast2m = 1'b1, kWr = 1'b0, mWr = 1'b0, rtcLpo = 1'b0, wdtEn = 1'b0;
   logic [3:0] irq = 4'h0;
   logic [2:0] modeSel = 3'h0;
   logic [1:0] xMode = 2'h0;
   logic [4:0] pllF = 5'h00;
   logic [7:0] kData = 8'h00, mData = 8'h00, pr = 8'ha5;
   logic sleepInstr, nvmBusy, cpuHalt, cpuClkEn, nvmClkEn, wakeStrobe, sleeping, rtcClkEn;
   logic rc2mOn, rc32mOn, rc32kOn, xoscOn, pllOn, f2On, lpoOn;
   logic [1:0] xModeOut;
   logic [4:0] pllMult;
   logic [7:0] rc2mCal, rc32mCal, rc32kCal, perClkEn;
   logic lpoTick, kTick, evtEn;
   logic [2:0] clkSel = 3'h0;
   smc_src_e sysClkSrc;
   int n_fail = 0, check_count = 0, cycles = 0, nLpo = 0, nK = 0;
   // idle, power-down, power-save, standby, extended standby
   logic [2:0] mTab [5] = '{SMC_MODE_IDLE, SMC_MODE_PDOWN, SMC_MODE_PSAVE, SMC_MODE_STDBY,
      SMC_MODE_ESTDBY};
   logic [3:0] good [5] = '{4'h1, 4'h2, 4'h8, 4'h4, 4'h8};
   logic [3:0] bad [5] = '{4'h0, 4'h9, 4'h1, 4'h9, 4'h1};
   logic [7:0] pTab [5] = '{8'h5a, 8'h00, 8'h00, 8'h00, 8'h00};
   logic rTab [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

   always #5 clk = ~clk;
   smc_cpu_model u_cpu (.clk(clk), .reset(reset), .sleepReq(sleepReq), .nvmStart(nvmStart),
      .cpuHalt(cpuHalt), .sleepInstr(sleepInstr), .nvmBusy(nvmBusy));
   smc_sleep_ctrl dut (.clk(clk), .reset(reset), .sleepInstr(sleepInstr),
      .sleepEnable(sleepEn), .sleepModeSel(modeSel), .nvmBusy(nvmBusy), .irqAny(irq[0]),
      .irqTwiAddrMatch(irq[1]), .irqPortAsync(irq[2]), .irqRtc(irq[3]), .rtcEnable(rtcEn),
      .cpuHalt(cpuHalt), .cpuClkEn(cpuClkEn), .nvmClkEn(nvmClkEn), .wakeStrobe(wakeStrobe),
      .sleeping(sleeping), .sysClkSel(clkSel), .rc32mEnable(rc32mEn), .rc32kEnable(rc32kEn),
      .xoscEnable(xoscEn), .xoscMode(xMode), .pllEnable(pllEn), .pllFactor(pllF),
      .flc2mEnable(flc2mEn), .flc32mEnable(1'b0), .flcFast2m(fast2m), .flcFast32m(1'b0),
      .rc32kCalWrite(kWr), .rc32kCalData(kData), .rc32mCalWrite(mWr), .rc32mCalData(mData),
      .rtcUsesLowPowerOsc(rtcLpo), .wdtEnable(wdtEn), .sysClkSrc(sysClkSrc), .rc2mOn(rc2mOn),
      .rc32mOn(rc32mOn), .rc32kOn(rc32kOn), .xoscOn(xoscOn), .xoscModeOut(xModeOut),
      .pllOn(pllOn), .pllMult(pllMult), .freq_lock_calibrator2mOn(f2On),
      .freq_lock_calibrator32mOn(), .rc2mCal(rc2mCal), .rc32mCal(rc32mCal),
      .rc32kCal(rc32kCal), .low_power_oscOn(lpoOn), .lowPowerTick(lpoTick),
      .lowPowerKhzTick(), .rc32kTick(kTick), .rc32kKhzTick(), .powerReduce(pr),
      .perClkEn(perClkEn), .rtcClkEn(rtcClkEn), .evtClkEn(evtEn));

   // ==========================================
   // shared tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkf(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task automatic nap(input logic [2:0] m);
      modeSel = m;
      sleepReq = 1'b1;
      tick(1);
      sleepReq = 1'b0;
      for (int i = 0; i < 30 && sleeping !== 1'b1; i++) tick(1);
   endtask
   task automatic rouse(input logic [3:0] w);
      irq = w;
      for (int i = 0; i < 30 && wakeStrobe !== 1'b1; i++) tick(1);
      chkf(wakeStrobe, 1'b1);
      irq = 4'h0;
      tick(3);
      chkf(cpuHalt, 1'b1);
      tick(1);
      chkf(cpuHalt, 1'b0);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ==========================================
   // tick pulses counted on the falling edge, clear of the launching edge
   always @(negedge clk) begin
      nLpo += int'(lpoTick);
      nK += int'(kTick);
   end

   // hang guard, run is about four thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         n_fail++;
         give_verdict();
      end
   end

   initial begin
      tick(16);
      reset = 1'b0;
      tick(2);
      chk(8'(sysClkSrc), 8'(SMC_SRC_RC2M));
      chk({rc32mOn, rc32kOn, xoscOn, pllOn, f2On, 3'h0}, 8'h00);
      chk(rc32kCal, 8'h80);
      chk(8'(pllMult), 8'h01);
      $display("reset test done");
      wdtEn = 1'b1;
      rc32kEn = 1'b1;
      tick(2);
      chkf(lpoOn, 1'b1);
      // one base period of each divider fits in this window
      tick(3198);
      chk(8'(nLpo), 8'h01);
      chk(8'(nK), 8'h01);
      wdtEn = 1'b0;
      rtcLpo = 1'b1;
      tick(2);
      chkf(lpoOn, 1'b1);
      rtcLpo = 1'b0;
      tick(2);
      chkf(lpoOn, 1'b0);
      for (int i = 0; i < 4; i++) begin
         xMode = 2'(i);
         tick(2);
         chk(8'(xModeOut), 8'(i));
      end
      pllF = 5'h00;
      tick(2);
      chk(8'(pllMult), 8'h01);
      pllF = 5'h1f;
      tick(2);
      chk(8'(pllMult), 8'h1f);
      {rc32mEn, rc32kEn, xoscEn, pllEn} = 4'hf;
      kData = 8'h5a;
      kWr = 1'b1;
      mData = 8'h33;
      mWr = 1'b1;
      tick(1);
      {kWr, mWr} = 2'b00;
      tick(2);
      chk({rc32mOn, rc32kOn, xoscOn, pllOn, 4'h0}, 8'hf0);
      chk(rc32kCal, 8'h5a);
      chk(rc32mCal, 8'h33);
      flc2mEn = 1'b1;
      tick(200);
      chkf(rc2mCal inside {[8'h7c:8'h7e]}, 1'b1);
      flc2mEn = 1'b0;
      pr = 8'h3c;
      tick(1);
      chk(perClkEn, 8'hc3);
      pr = 8'ha5;
      tick(1);
      $display("clock source test done");
      for (int i = 0; i < 5; i++) begin
         nap(mTab[i]);
         chkf(sleeping, 1'b1);
         chk(perClkEn, pTab[i]);
         chkf(rtcClkEn, rTab[i]);
         chkf(rc32mOn, i == 0 || i > 2);
         chkf(evtEn, i == 0);
         irq = bad[i];
         tick(4);
         chkf(sleeping, 1'b1);
         rouse(good[i]);
         chkf(cpuHalt, 1'b0);
         $display("sleep mode %0d test done", mTab[i]);
      end
      chk(rc32kCal, 8'h5a);
      sleepEn = 1'b0;
      nap(SMC_MODE_IDLE);
      chkf(cpuHalt, 1'b0);
      sleepEn = 1'b1;
      nap(3'h1);
      chkf(cpuHalt, 1'b0);
      nvmStart = 1'b1;
      sleepReq = 1'b1;
      modeSel = SMC_MODE_IDLE;
      tick(1);
      {nvmStart, sleepReq} = 2'b00;
      tick(4);
      chk({sleeping, cpuHalt, 6'h00}, 8'h40);
      tick(10);
      chkf(sleeping, 1'b1);
      rouse(4'h1);
      $display("sleep refusal and drain test done");
      clkSel = 3'h4;
      tick(2);
      chk(8'(sysClkSrc), 8'(SMC_SRC_PLL));
      nap(SMC_MODE_PDOWN);
      reset = 1'b1;
      tick(2);
      // selector still asks for the pll, reset must win
      chk(8'(sysClkSrc), 8'(SMC_SRC_RC2M));
      clkSel = 3'h0;
      reset = 1'b0;
      tick(1);
      chk({sleeping, cpuHalt, 6'h00}, 8'h00);
      chk(rc32kCal, 8'h80);
      $display("reset in sleep test done");
      give_verdict();
   end
endmodule // sleep_mode_clock_gating_tb

/* tb/smc_cpu_model.sv */
// cpu and memory side model: sleep instruction issue and nvm programming
module smc_cpu_model #(
   parameter int BUSY_CYC = 10
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sleepReq,
   input wire logic nvmStart,
   input wire logic cpuHalt,
   output logic sleepInstr = 1'b0,
   output logic nvmBusy
);
   timeunit 1ns;
   timeprecision 1ns;
   int busyLeft = 0;
   always @(posedge clk) sleepInstr <= #1 sleepReq && !cpuHalt && !reset;
   always @(posedge clk) begin
      if (reset) busyLeft <= #1 0;
      else if (nvmStart) busyLeft <= #1 BUSY_CYC;
      else if (busyLeft > 0) busyLeft <= #1 busyLeft - 1;
   end
   assign nvmBusy = (busyLeft > 0);
endmodule // smc_cpu_model

/* tb/smc_sleep_checker.sv */
// assertion checker for the sleep and clock gating controller
module smc_sleep_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic sleepInstr,
   input wire logic sleepEnable,
   input wire logic [2:0] sleepModeSel,
   input wire logic nvmBusy,
   input wire logic cpuHalt,
   input wire logic cpuClkEn,
   input wire logic nvmClkEn,
   input wire logic wakeStrobe,
   input wire logic sleeping,
   input wire smc_pkg::smc_src_e sysClkSrc,
   input wire logic rc2mOn,
   input wire logic pllOn,
   input wire logic [4:0] pllMult,
   input wire logic [7:0] powerReduce,
   input wire logic [7:0] perClkEn
);
   timeunit 1ns;
   timeprecision 1ns;
   import smc_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // ==========================================
   // boot and sleep entry
   AST_BOOT_SRC: assert property ($fell(reset) |-> sysClkSrc == SMC_SRC_RC2M && rc2mOn && !pllOn)
      else $error("boot clock state wrong");
   AST_SLEEP_TAKE: assert property (!cpuHalt && sleepInstr && sleepEnable &&
      sleepModeSel inside {3'h0, 3'h2, 3'h3, 3'h6, 3'h7} |=> cpuHalt && !cpuClkEn)
      else $error("sleep not taken");
   AST_SLEEP_OFF: assert property (!cpuHalt && sleepInstr && !sleepEnable |=> !cpuHalt)
      else $error("sleep taken while disabled");
   AST_DRAIN_WAIT: assert property (cpuHalt && !cpuClkEn && !sleeping && nvmBusy |=> !sleeping)
      else $error("slept during programming");
   AST_SLEEP_CLKS: assert property (sleeping |-> cpuHalt && !cpuClkEn && !nvmClkEn)
      else $error("core clocks run in sleep");
   // ==========================================
   // wake and gating
   AST_WAKE_HALT: assert property (wakeStrobe |-> cpuHalt [*4] ##1 !cpuHalt)
      else $error("wake halt length wrong");
   AST_WAKE_CLKS: assert property (wakeStrobe |-> !sleeping && cpuClkEn && nvmClkEn)
      else $error("clocks off at wake");
   AST_PR_GATE: assert property (!sleeping |-> perClkEn == ~powerReduce)
      else $error("peripheral gating wrong");
   AST_PLL_RANGE: assert property (pllMult != 5'h00)
      else $error("pll multiplier zero");
endmodule // smc_sleep_checker

bind smc_sleep_ctrl smc_sleep_checker u_chk (.clk, .reset, .sleepInstr, .sleepEnable,
   .sleepModeSel, .nvmBusy, .cpuHalt, .cpuClkEn, .nvmClkEn, .wakeStrobe, .sleeping,
   .sysClkSrc, .rc2mOn, .pllOn, .pllMult, .powerReduce, .perClkEn);
